// File: hw/down_timer.sv
// loadable down counter with a zero flag
`timescale 1ns/10ps
module down_timer (
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic load,
  input wire logic [gate_ctrl_pkg::TIMER_W-1:0] load_value,
  output logic count_zero
);

  logic [gate_ctrl_pkg::TIMER_W-1:0] count_q;

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_value;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign count_zero = (count_q == '0);

endmodule

// File: hw/gate_ctrl_pkg.sv
// constants, types and helpers shared by the gate control logic
package gate_ctrl_pkg;

  localparam int NUM_PHASES = 3;

  // timing, clock is 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int DT_STEP_NS = 50;
  localparam int DT_STEP_CYCLES = (DT_STEP_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int DT_MAX_NS = 12000;
  // a step is a whole number of clocks, so cap the code at the 12 us span
  localparam int DT_MAX_CODE = DT_MAX_NS /
                               (DT_STEP_CYCLES * CLK_PERIOD_NS);
  localparam int BLANK_NS = 1000;
  localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;

  localparam int TIMER_W = 9;
  localparam int DT_CODE_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SYNC_W = 2 * NUM_PHASES + 2; // cmds, enable, comparator

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DEADTIME = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_STATUS = 8'h10;

  // field positions
  localparam int ST_OC_BIT = 0;
  localparam int PS_HS_LSB = 0;
  localparam int PS_LS_LSB = 3;
  localparam int PS_BOOT_LSB = 6;
  localparam int PS_ENABLED_BIT = 9;
  localparam int PS_OC_LIVE_BIT = 10;

  // command codes and reset values
  localparam logic [7:0] CMD_CLEAR_INT_GROUP0 = 8'h01;
  localparam logic [DT_CODE_W-1:0] DEADTIME_RESET = 8'h00;
  localparam logic [0:0] MASK_RESET = 1'h0;
  localparam logic [0:0] STATUS_RESET = 1'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic hs;
    logic ls;
  } phase_pair_type;

  typedef enum logic [2:0] {
    PH_OFF,
    PH_DEAD_HS,
    PH_HS_ON,
    PH_DEAD_LS,
    PH_LS_ON
  } phase_state_type;

  // programmed code to deadtime length in clock cycles
  function automatic logic [TIMER_W-1:0] dt_cycles(
      input logic [DT_CODE_W-1:0] code);
    logic [TIMER_W-1:0] ext;
    ext = {1'h0, code};
    return TIMER_W'(ext * TIMER_W'(DT_STEP_CYCLES));
  endfunction

endpackage

// File: hw/sync_two_ff.sv
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int WIDTH = gate_ctrl_pkg::SYNC_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q feeds only sync_q
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: hw/three_phase_gate_control_logic.sv
// three-phase gate control: deadtime, bootstrap lock, blanking, faults
//
// Function
// - commands act on leading edges, not levels
// - edge drops complement now, selected after deadtime
// - deadtime starts when the other FET turns off
// - high side waits for one low-side pulse
// - high side may stay on indefinitely
// - blank current limit after each command change
// - overcurrent changes flag pin and latches fault
// - latched overcurrent shows in status bit 0
// - unmasked overcurrent fault raises interrupt output
// - interrupt holds until fault gone and cleared
// - status registers readable at any time
// - deadtime programmable in 50 ns steps; the code rounds each step up to 2 clocks (80 ns)
// - gates follow commands only when fully enabled
// - sleep clears fault and register contents
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
module three_phase_gate_control_logic (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sleep_reset_n,
  input wire logic enable_input_a,
  input wire logic enable_input_b,
  input wire logic [gate_ctrl_pkg::NUM_PHASES-1:0] high_side_cmd_input,
  input wire logic [gate_ctrl_pkg::NUM_PHASES-1:0] low_side_cmd_input,
  input wire logic oc_comparator_in,
  input wire gate_ctrl_pkg::reg_req_type reg_req,
  output logic [gate_ctrl_pkg::DATA_W-1:0] reg_rdata,
  output logic [gate_ctrl_pkg::NUM_PHASES-1:0] high_side_gate,
  output logic [gate_ctrl_pkg::NUM_PHASES-1:0] low_side_gate,
  output logic [gate_ctrl_pkg::NUM_PHASES-1:0] current_limit_blank,
  output logic overcurrent_flag_pin,
  output logic interrupt_out
);

  localparam int NP = gate_ctrl_pkg::NUM_PHASES;

  // every pin input crosses two flops before use
  logic [gate_ctrl_pkg::SYNC_W-1:0] pins_raw;
  logic [gate_ctrl_pkg::SYNC_W-1:0] pins_sync;

  // top bit comparator, then enable, then hs and ls by phase
  assign pins_raw = {oc_comparator_in,
                     (sleep_reset_n & enable_input_a & enable_input_b),
                     high_side_cmd_input,
                     low_side_cmd_input};

  sync_two_ff #(
    .WIDTH(gate_ctrl_pkg::SYNC_W)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // sleep is sampled separately so that it can clear on its own
  logic [0:0] sleep_n_sync;

  sync_two_ff #(
    .WIDTH(1)
  ) u_sleep_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(sleep_reset_n),
    .sync_out(sleep_n_sync)
  );

  logic clear_all;
  logic enabled;
  logic oc_live;
  gate_ctrl_pkg::phase_pair_type cmd_s [NP];
  gate_ctrl_pkg::phase_pair_type cmd_prev_q [NP];

  // sleep flops reset low, so clearing outlasts reset by two cycles
  assign clear_all = !rst_n || !sleep_n_sync[0];
  assign oc_live = pins_sync[gate_ctrl_pkg::SYNC_W-1];
  assign enabled = pins_sync[gate_ctrl_pkg::SYNC_W-2];

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      cmd_s[p].hs = pins_sync[NP + p];
      cmd_s[p].ls = pins_sync[p];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (clear_all) begin
        cmd_prev_q[p] <= '0;
      end else begin
        cmd_prev_q[p] <= cmd_s[p];
      end
    end
  end

  logic [NP-1:0] hs_rise;
  logic [NP-1:0] ls_rise;
  logic [NP-1:0] cmd_change;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      hs_rise[p] = cmd_s[p].hs & ~cmd_prev_q[p].hs;
      ls_rise[p] = cmd_s[p].ls & ~cmd_prev_q[p].ls;
      cmd_change[p] = (cmd_s[p] != cmd_prev_q[p]);
    end
  end

  // register file
  logic [gate_ctrl_pkg::DT_CODE_W-1:0] deadtime_code_q;
  logic [0:0] irq_mask_q;
  logic [0:0] status0_q;
  logic [gate_ctrl_pkg::DATA_W-1:0] rdata_q;
  logic status_read;
  logic clear_cmd;

  assign status_read = reg_req.rd &&
                       (reg_req.addr == gate_ctrl_pkg::ADDR_STATUS0);
  assign clear_cmd = reg_req.wr &&
                     (reg_req.addr == gate_ctrl_pkg::ADDR_COMMAND) &&
                     (reg_req.wdata[7:0] ==
                      gate_ctrl_pkg::CMD_CLEAR_INT_GROUP0);

  // codes above the 12 us span saturate instead of wrapping
  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      deadtime_code_q <= gate_ctrl_pkg::DEADTIME_RESET;
    end else if (reg_req.wr &&
                 reg_req.addr == gate_ctrl_pkg::ADDR_DEADTIME) begin
      if (reg_req.wdata > gate_ctrl_pkg::DATA_W'(
            gate_ctrl_pkg::DT_MAX_CODE)) begin
        deadtime_code_q <= gate_ctrl_pkg::DT_CODE_W'(
            gate_ctrl_pkg::DT_MAX_CODE);
      end else begin
        deadtime_code_q <=
            reg_req.wdata[gate_ctrl_pkg::DT_CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      irq_mask_q <= gate_ctrl_pkg::MASK_RESET;
    end else if (reg_req.wr &&
                 reg_req.addr == gate_ctrl_pkg::ADDR_IRQ_MASK) begin
      irq_mask_q <= reg_req.wdata[gate_ctrl_pkg::ST_OC_BIT];
    end
  end

  // a live fault re-sets the bit, so a clear only sticks once it is gone
  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      status0_q <= gate_ctrl_pkg::STATUS_RESET;
    end else if (oc_live) begin
      status0_q <= 1'b1;
    end else if (status_read || clear_cmd) begin
      status0_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      overcurrent_flag_pin <= 1'b0;
    end else begin
      overcurrent_flag_pin <= oc_live;
    end
  end

  assign interrupt_out = |(status0_q & irq_mask_q);

  // phase state machines
  gate_ctrl_pkg::phase_state_type state_q [NP];
  logic [NP-1:0] boot_ok_q;
  logic [NP-1:0] dt_load;
  logic [NP-1:0] dt_zero;
  logic [NP-1:0] blank_zero;
  logic [NP-1:0] blank_load;
  logic [gate_ctrl_pkg::TIMER_W-1:0] dt_value;

  // one shared setting feeds all three phase timers
  assign dt_value = gate_ctrl_pkg::dt_cycles(deadtime_code_q);

  // low side wins when both edges land together, as the safer choice
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      dt_load[p] = 1'b0;
      if (enabled && !clear_all) begin
        if (ls_rise[p]) begin
          dt_load[p] = (state_q[p] != gate_ctrl_pkg::PH_LS_ON) &&
                       (state_q[p] != gate_ctrl_pkg::PH_DEAD_LS);
        end else if (hs_rise[p]) begin
          dt_load[p] = (state_q[p] != gate_ctrl_pkg::PH_HS_ON) &&
                       (state_q[p] != gate_ctrl_pkg::PH_DEAD_HS);
        end
      end
      blank_load[p] = enabled && cmd_change[p];
    end
  end

  for (genvar g = 0; g < NP; g++) begin : g_phase
    down_timer u_dead (
      .sys_clk(sys_clk),
      .clear(clear_all),
      .load(dt_load[g]),
      .load_value(dt_value),
      .count_zero(dt_zero[g])
    );

    down_timer u_blank (
      .sys_clk(sys_clk),
      .clear(clear_all || !enabled),
      .load(blank_load[g]),
      .load_value(gate_ctrl_pkg::TIMER_W'(gate_ctrl_pkg::BLANK_CYCLES)),
      .count_zero(blank_zero[g])
    );
  end

  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (clear_all || !enabled) begin
        state_q[p] <= gate_ctrl_pkg::PH_OFF;
      end else if (dt_load[p] && ls_rise[p]) begin
        state_q[p] <= gate_ctrl_pkg::PH_DEAD_LS;
      end else if (dt_load[p]) begin
        state_q[p] <= gate_ctrl_pkg::PH_DEAD_HS;
      end else begin
        case (state_q[p])
          gate_ctrl_pkg::PH_DEAD_HS: begin
            if (dt_zero[p]) begin
              if (boot_ok_q[p]) begin
                state_q[p] <= gate_ctrl_pkg::PH_HS_ON;
              end else begin
                state_q[p] <= gate_ctrl_pkg::PH_OFF;
              end
            end
          end
          gate_ctrl_pkg::PH_DEAD_LS: begin
            if (dt_zero[p]) begin
              state_q[p] <= gate_ctrl_pkg::PH_LS_ON;
            end
          end
          // on states hold with no time limit until a new edge
          gate_ctrl_pkg::PH_HS_ON: state_q[p] <= state_q[p];
          gate_ctrl_pkg::PH_LS_ON: state_q[p] <= state_q[p];
          gate_ctrl_pkg::PH_OFF: state_q[p] <= state_q[p];
          default: state_q[p] <= gate_ctrl_pkg::PH_OFF;
        endcase
      end
    end
  end

  // the lock rearms on every exit from enable; long low-side idle is
  // not tracked, the host must refresh the bootstrap itself
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (clear_all || !enabled) begin
        boot_ok_q[p] <= 1'b0;
      end else if (state_q[p] == gate_ctrl_pkg::PH_LS_ON) begin
        boot_ok_q[p] <= 1'b1;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      high_side_gate[p] = (state_q[p] == gate_ctrl_pkg::PH_HS_ON);
      low_side_gate[p] = (state_q[p] == gate_ctrl_pkg::PH_LS_ON);
      current_limit_blank[p] = !blank_zero[p];
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (clear_all || !reg_req.rd) begin
      rdata_q <= '0;
    end else begin
      case (reg_req.addr)
        gate_ctrl_pkg::ADDR_STATUS0: begin
          rdata_q <= gate_ctrl_pkg::DATA_W'(status0_q);
        end
        gate_ctrl_pkg::ADDR_IRQ_MASK: begin
          rdata_q <= gate_ctrl_pkg::DATA_W'(irq_mask_q);
        end
        gate_ctrl_pkg::ADDR_DEADTIME: begin
          rdata_q <= gate_ctrl_pkg::DATA_W'(deadtime_code_q);
        end
        gate_ctrl_pkg::ADDR_PHASE_STATUS: begin
          rdata_q <= gate_ctrl_pkg::DATA_W'({oc_live, enabled, boot_ok_q,
                                             low_side_gate,
                                             high_side_gate});
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// File: tb/gate_ctrl_properties.sv
// concurrent checks on the ports of the gate control block
`timescale 1ns/10ps
module gate_ctrl_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sleep_reset_n,
  input wire logic enable_input_a,
  input wire logic enable_input_b,
  input wire logic [gate_ctrl_pkg::NUM_PHASES-1:0] low_side_cmd_input,
  input wire logic oc_comparator_in,
  input wire gate_ctrl_pkg::reg_req_type reg_req,
  input wire logic [gate_ctrl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [gate_ctrl_pkg::NUM_PHASES-1:0] high_side_gate,
  input wire logic [gate_ctrl_pkg::NUM_PHASES-1:0] low_side_gate,
  input wire logic [gate_ctrl_pkg::NUM_PHASES-1:0] current_limit_blank,
  input wire logic overcurrent_flag_pin,
  input wire logic interrupt_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] quiet_q;
  logic [2:0] boot_q;
  logic en_pins;
  assign en_pins = enable_input_a && enable_input_b && sleep_reset_n;
  // settle time after reset or sleep, to cover the input synchronisers
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !sleep_reset_n) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  // cleared on the pins, ahead of the design's synchroniser lag
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !en_pins) boot_q <= 3'h0;
    else boot_q <= boot_q | low_side_gate;
  end
  sequence disabled_run;
    (!en_pins) [*4];
  endsequence
  sequence fault_held;
    $past(oc_comparator_in, 2) && interrupt_out;
  endsequence
  a_no_overlap:
    assert property ((high_side_gate & low_side_gate) == 3'h0)
    else $error("high and low gate on together");
  a_rdata_idle:
    assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_flag_delay:
    assert property (quiet_q == 3'h7 |->
      overcurrent_flag_pin == $past(oc_comparator_in, 3))
    else $error("flag pin does not follow comparator");
  a_irq_hold:
    assert property (quiet_q == 3'h7 && !reg_req.wr ##0 fault_held
      |=> interrupt_out)
    else $error("interrupt dropped while fault present");
  a_irq_cause:
    assert property ($rose(interrupt_out) && !$past(reg_req.wr)
      |-> overcurrent_flag_pin)
    else $error("interrupt without fault");
  a_blank_start:
    assert property (quiet_q == 3'h7 && en_pins &&
      $changed(low_side_cmd_input) |-> ##[1:5] current_limit_blank != 3'h0)
    else $error("no blanking after command change");
  a_blank_hold:
    assert property ($rose(current_limit_blank[0]) |->
      current_limit_blank[0] [*8])
    else $error("blanking window too short");
  a_off_disabled:
    assert property (disabled_run |-> (high_side_gate | low_side_gate) == 3'h0)
    else $error("gate on while disabled");
  a_boot_first:
    assert property ((high_side_gate & ~$past(high_side_gate) & ~boot_q)
      == 3'h0)
    else $error("high side on before low side pulse");
endmodule

bind three_phase_gate_control_logic
  gate_ctrl_properties gate_ctrl_properties_i (
  .sys_clk, .rst_n, .sleep_reset_n, .enable_input_a, .enable_input_b,
  .low_side_cmd_input, .oc_comparator_in, .reg_req, .reg_rdata,
  .high_side_gate, .low_side_gate, .current_limit_blank,
  .overcurrent_flag_pin, .interrupt_out);

// File: tb/host_pin_model.sv
// host side model: pulses the direct command pins of the pre-driver
`timescale 1ns/10ps
module host_pin_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic hs_sel,
  input wire logic [1:0] phase,
  input wire logic [3:0] hold,
  output logic [2:0] high_side_cmd_input,
  output logic [2:0] low_side_cmd_input
);
  logic [3:0] left_q = 4'h0;
  logic hs_q = 1'h0;
  logic [1:0] ph_q = 2'h0;
  // hold must outlast the two-stage input synchroniser
  always_ff @(posedge sys_clk) begin
    if (go) begin
      left_q <= hold;
      hs_q <= hs_sel;
      ph_q <= phase;
    end else if (left_q != 4'h0) left_q <= left_q - 4'h1;
  end
  // a pulse, not a level: only its leading edge commands
  always_comb begin
    high_side_cmd_input = 3'h0;
    low_side_cmd_input = 3'h0;
    if (left_q != 4'h0 && hs_q) high_side_cmd_input[ph_q] = 1'h1;
    if (left_q != 4'h0 && !hs_q) low_side_cmd_input[ph_q] = 1'h1;
  end
endmodule

// File: tb/three_phase_gate_control_logic_tb.sv
// self-checking bench for the three-phase gate control block
`timescale 1ns/10ps
module three_phase_gate_control_logic_tb;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic sleep_n = 1'h1;
  logic en_a = 1'h0;
  logic en_b = 1'h1;
  logic oc = 1'h0;
  logic go = 1'h0;
  logic hs_sel = 1'h0;
  logic [1:0] ph = 2'h0;
  logic rd_d = 1'h0;
  gate_ctrl_pkg::reg_req_type req = '0;
  logic [2:0] hs_pin, ls_pin, hs_g, ls_g, blank;
  logic [31:0] rdata, seed;
  logic flag, irq;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int num_checks = 0;
  int lat0, n, k;
  always #20 sys_clk = ~sys_clk;
  three_phase_gate_control_logic three_phase_gate_control_logic_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .sleep_reset_n(sleep_n),
    .enable_input_a(en_a), .enable_input_b(en_b),
    .high_side_cmd_input(hs_pin), .low_side_cmd_input(ls_pin),
    .oc_comparator_in(oc), .reg_req(req), .reg_rdata(rdata),
    .high_side_gate(hs_g), .low_side_gate(ls_g),
    .current_limit_blank(blank), .overcurrent_flag_pin(flag),
    .interrupt_out(irq));
  host_pin_model host_pin_model_i (.sys_clk(sys_clk), .go(go),
    .hs_sel(hs_sel), .phase(ph), .hold(4'h4),
    .high_side_cmd_input(hs_pin), .low_side_cmd_input(ls_pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    err_count++;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("read %h want %h", got, exp));
  endtask
  task automatic check_bit(input logic got, input logic exp, input string w);
    num_checks++;
    if (got !== exp) fail(w);
  endtask
  task automatic check_count(input int got, input int exp);
    num_checks++;
    if (got != exp) fail($sformatf("latency %0d want %0d", got, exp));
  endtask
  // read answers are judged here, oldest note first
  always @(posedge sys_clk) begin
    if (rd_d && exp_q.size() != 0) check_word(rdata, exp_q.pop_front());
    rd_d <= req.rd;
  end
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge sys_clk);
    req.wr <= 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    exp_q.push_back(e);
    @(posedge sys_clk);
    req.rd <= 1'h0;
  endtask
  task automatic pulse(input logic h, input int p);
    @(posedge sys_clk);
    go <= 1'h1;
    hs_sel <= h;
    ph <= 2'(p);
    @(posedge sys_clk);
    go <= 1'h0;
  endtask
  task automatic wait_on(input logic h, input int p, output int c);
    c = 0;
    while ((h ? hs_g[p] : ls_g[p]) !== 1'h1 && c < 400) begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 400) begin
      fail("gate never turned on");
      report_and_stop();
    end
  endtask
  task automatic report_and_stop;
    repeat (2) @(posedge sys_clk);
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    seed = 32'h000140E3;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    reg_rd(gate_ctrl_pkg::ADDR_IRQ_MASK, 32'h0);
    reg_rd(gate_ctrl_pkg::ADDR_DEADTIME, 32'h0);
    reg_wr(gate_ctrl_pkg::ADDR_STATUS0, 32'hFFFFFFFF);
    reg_wr(8'h14, 32'hFFFFFFFF);
    reg_rd(gate_ctrl_pkg::ADDR_STATUS0, 32'h0);
    reg_rd(8'h14, 32'h0);
    reg_rd(gate_ctrl_pkg::ADDR_PHASE_STATUS, 32'h0);
    $display("reset values done");
    en_a <= 1'h1;
    // two sync flops, edge, one zero deadtime cycle, then the gate
    lat0 = 5;
    repeat (4) @(posedge sys_clk);
    for (int p = 0; p < 3; p++) begin
      pulse(1'h1, p);
      repeat (10) @(posedge sys_clk);
      check_bit(hs_g[p], 1'h0, "high side before charge");
      pulse(1'h0, p);
      wait_on(1'h0, p, n);
      check_count(n, lat0);
      pulse(1'h1, p);
      wait_on(1'h1, p, n);
      check_count(n, lat0);
      check_bit(ls_g[p], 1'h0, "low side left on");
    end
    repeat (200) @(posedge sys_clk);
    reg_rd(gate_ctrl_pkg::ADDR_PHASE_STATUS, 32'h000003C7);
    $display("bootstrap and full duty done");
    reg_wr(gate_ctrl_pkg::ADDR_DEADTIME, 32'h000000FF);
    k = gate_ctrl_pkg::DT_MAX_CODE;
    reg_rd(gate_ctrl_pkg::ADDR_DEADTIME, 32'(k));
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      k = 8 + int'(seed[2:0]);
      reg_wr(gate_ctrl_pkg::ADDR_DEADTIME, 32'(k));
      reg_rd(gate_ctrl_pkg::ADDR_DEADTIME, 32'(k));
      pulse(1'(i), 0);
      repeat (6) @(posedge sys_clk);
      check_bit(hs_g[0] | ls_g[0], 1'h0, "gate on in deadtime");
      wait_on(1'(i), 0, n);
      check_count(n + 6, lat0 + k * gate_ctrl_pkg::DT_STEP_CYCLES);
    end
    $display("deadtime done");
    en_b <= 1'h0;
    repeat (5) @(posedge sys_clk);
    check_bit(|(hs_g | ls_g), 1'h0, "gate on while disabled");
    reg_rd(gate_ctrl_pkg::ADDR_PHASE_STATUS, 32'h0);
    en_b <= 1'h1;
    repeat (4) @(posedge sys_clk);
    pulse(1'h1, 1);
    repeat (5) @(posedge sys_clk);
    check_bit(blank[1], 1'h1, "no blanking after edge");
    // the falling edge restarts the window four cycles later
    repeat (gate_ctrl_pkg::BLANK_CYCLES + 2) @(posedge sys_clk);
    check_bit(blank[1], 1'h1, "blanking ended early");
    @(posedge sys_clk);
    check_bit(blank[1], 1'h0, "blanking too long");
    repeat (12) @(posedge sys_clk);
    check_bit(hs_g[1], 1'h0, "high side after re-enable");
    $display("disable done");
    oc <= 1'h1;
    repeat (6) @(posedge sys_clk);
    check_bit(flag, 1'h1, "flag pin");
    check_bit(irq, 1'h0, "masked interrupt");
    oc <= 1'h0;
    repeat (6) @(posedge sys_clk);
    reg_rd(gate_ctrl_pkg::ADDR_STATUS0, 32'h1);
    reg_rd(gate_ctrl_pkg::ADDR_STATUS0, 32'h0);
    reg_wr(gate_ctrl_pkg::ADDR_IRQ_MASK, 32'h1);
    reg_rd(gate_ctrl_pkg::ADDR_IRQ_MASK, 32'h1);
    oc <= 1'h1;
    repeat (6) @(posedge sys_clk);
    check_bit(irq, 1'h1, "interrupt");
    reg_rd(gate_ctrl_pkg::ADDR_PHASE_STATUS, 32'h00000600);
    reg_wr(gate_ctrl_pkg::ADDR_COMMAND, 32'h1);
    reg_rd(gate_ctrl_pkg::ADDR_STATUS0, 32'h1);
    oc <= 1'h0;
    repeat (6) @(posedge sys_clk);
    reg_wr(gate_ctrl_pkg::ADDR_COMMAND, 32'h2);
    repeat (2) @(posedge sys_clk);
    check_bit(irq, 1'h1, "interrupt held");
    reg_wr(gate_ctrl_pkg::ADDR_COMMAND,
           32'(gate_ctrl_pkg::CMD_CLEAR_INT_GROUP0));
    repeat (2) @(posedge sys_clk);
    check_bit(irq, 1'h0, "interrupt cleared");
    reg_rd(gate_ctrl_pkg::ADDR_STATUS0, 32'h0);
    $display("overcurrent done");
    sleep_n <= 1'h0;
    repeat (4) @(posedge sys_clk);
    sleep_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    reg_rd(gate_ctrl_pkg::ADDR_IRQ_MASK, 32'h0);
    reg_rd(gate_ctrl_pkg::ADDR_DEADTIME, 32'h0);
    $display("sleep done");
    report_and_stop();
  end
endmodule
